// file: verilog/pao_map.svh
/*
 * Constants for the pipeline output alignment block: widths, latency,
 * stage counts and field positions.
 * Assumes inclusion by bare name from the package and the port-level checker.
 */
`ifndef PAO_MAP_SVH
`define PAO_MAP_SVH
`define PAO_STAGES      8
`define PAO_STAGE_BITS  2
`define PAO_RAW_BITS    18
`define PAO_OUT_BITS    10
`define PAO_LATENCY     7
`define PAO_RETIME      2
`define PAO_FIFO_DEPTH  8
`define PAO_PAD         4
`define PAO_FIXED       3
`define PAO_PHASE_W     2
`define PAO_PH1         2'h1
`define PAO_PH2         2'h2
`define PAO_PH_NONE     2'h0
`endif

// file: verilog/pao_pkg.sv
/*
 * Types shared by the pipeline output alignment block.
 * Assumes pao_map.svh is on the include path.
 */
`include "pao_map.svh"
package pao_pkg;
  // Two-phase generator states, Gray ordered
  typedef enum logic [1:0] {
    PAO_PH1_S  = 2'h0,
    PAO_GAP1_S = 2'h1,
    PAO_PH2_S  = 2'h3,
    PAO_GAP2_S = 2'h2
  } pao_phase_e;
  typedef logic [`PAO_RAW_BITS-1:0] pao_raw_t;
  typedef logic [`PAO_OUT_BITS-1:0] pao_word_t;
endpackage : pao_pkg

// file: verilog/pao_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
module pao_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("pao_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];      // Storage
  logic [AW:0]      wp_r, wp_nxt;       // Write pointer
  logic [AW:0]      rp_r, rp_nxt;       // Read pointer
  logic             push, pop;
  // Full and empty from pointer wrap bits
  assign in_ready_o  = !((wp_r[AW] != rp_r[AW]) &&
                         (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid_o = (wp_r != rp_r);
  assign out_data_o  = mem_r[rp_r[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  // Next pointers
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end
  // Pointer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule : pao_fifo

// file: verilog/pao_corrector.sv
/*
 * Error correction: adds the overlapping two-bit stage results into one
 * ten-bit two's complement word. Purely combinational.
 * Assumes the eighteen-bit input is already time aligned.
 */
`timescale 1ns/10ps
module pao_corrector
  import pao_pkg::*;
(
  input  wire pao_pkg::pao_raw_t  raw_i,
  output pao_pkg::pao_word_t      word_o
);
  // Overlap-add correction
  // Each stage weight is 2^(8-k); the redundancy bit of one stage overlaps
  // the decision bit of the next, so carries absorb comparator errors.
  function automatic pao_word_t correct(input pao_raw_t r);
    logic [`PAO_OUT_BITS:0] acc;
    acc = '0;
    for (int k = 0; k <= `PAO_STAGES; k++) begin
      acc = acc + ({{(`PAO_OUT_BITS-1){1'b0}},
                    r[`PAO_RAW_BITS-1-2*k -: 2]} << (`PAO_STAGES - k));
    end
    // Offset-binary sum to two's complement by MSB flip
    return {~acc[`PAO_OUT_BITS-1], acc[`PAO_OUT_BITS-2:0]};
  endfunction : correct
  assign word_o = correct(raw_i);
endmodule : pao_corrector

// file: verilog/pao_top.sv
/*
 * Digital back end of the pipelined converter: phase generation, stage
 * alignment delay line, correction, output FIFO, double retiming and
 * format/enable handling of the result bus.
 * Assumes stage results arrive synchronously with sys_clk_i; each stage
 * bit pair is presented in the cycle its stage resolves the sample.
 */
`timescale 1ns/10ps
module pao_top
  import pao_pkg::*;
#(
  parameter int STAGES = `PAO_STAGES
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic [2*`PAO_STAGES+1:0]    stage_bits_i,
  input  wire logic                        output_format_select_i,
  input  wire logic                        out_enable_n_i,
  output logic [`PAO_PHASE_W-1:0]          phase_o,
  output logic [`PAO_STAGES:0]             stage_amp_o,
  output logic [`PAO_OUT_BITS-1:0]         conversion_result_bus_o,
  output logic [`PAO_OUT_BITS-1:0]         conversion_result_bus_oe_o,
  output logic                             result_valid_o
);
  import pao_pkg::*;

  // Latency budget, counted in clock edges after the flash pair is taken:
  //   edge 0       correction register captures the aligned word
  //   edges 1..4   padding taps carry the word and its valid flag
  //   edge 5       FIFO write; the head falls through at once
  //   edge 6       first retiming stage
  //   edge 7       second retiming stage drives the result bus
  // The padding exists only to land the word on the seventh edge; the
  // fixed part is the FIFO write plus the two retiming stages.
  // A capture circuit can therefore count edges from any flash pair taken from the fourth
  // edge after reset on and find the matching word without looking at the valid flag;
  // words from the first three edges are never written into the FIFO.
  // Changing the padding depth moves every result by the same amount.

  // Elaboration checks on the constants this logic depends on
  initial begin
    if (STAGES != `PAO_STAGES)
      $error("pao_top: only eight stages are supported");
    // Padding plus fixed stages must make up the whole latency
    if (`PAO_LATENCY != `PAO_PAD + `PAO_FIXED)
      $error("pao_top: latency budget does not add up");
    // Aligned word holds every stage pair plus the flash pair
    if (`PAO_RAW_BITS != `PAO_STAGE_BITS * (`PAO_STAGES + 1))
      $error("pao_top: raw word width mismatch");
    // At least one padding tap is assumed by the tap loops
    if (`PAO_PAD < 1)
      $error("pao_top: padding needs at least one tap");
  end

  // Sign bit flip
  // The two output codes differ only in the top bit
  function automatic pao_word_t flip_msb(input pao_word_t w);
    flip_msb                  = w;
    flip_msb[`PAO_OUT_BITS-1] = ~w[`PAO_OUT_BITS-1];
  endfunction : flip_msb

  // Aligned depth: stage k needs (STAGES - k) delays to meet the flash
  localparam int ND = `PAO_STAGES;

  // ---------------- Phase generation ----------------
  pao_phase_e               ph_r, ph_nxt;        // Phase state
  logic [`PAO_PHASE_W-1:0]  phase_r, phase_nxt;  // Registered phases
  logic [`PAO_STAGES:0]     amp_r, amp_nxt;      // Per-stage amplify flag

  always_comb begin
    ph_nxt = ph_r;
    unique case (ph_r)
      PAO_PH1_S:  ph_nxt = PAO_GAP1_S;
      PAO_GAP1_S: ph_nxt = PAO_PH2_S;
      PAO_PH2_S:  ph_nxt = PAO_GAP2_S;
      PAO_GAP2_S: ph_nxt = PAO_PH1_S;
    endcase
    // Gap states drive neither phase, so they never overlap
    unique case (ph_nxt)
      PAO_PH1_S:  phase_nxt = `PAO_PH1;
      PAO_PH2_S:  phase_nxt = `PAO_PH2;
      default:    phase_nxt = `PAO_PH_NONE;
    endcase
  end

  always_comb begin
    for (int k = 0; k <= `PAO_STAGES; k++) begin
      amp_nxt[k] = (phase_nxt == `PAO_PH2) ^ k[0];
    end
  end

  // Phase registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph_r    <= PAO_PH1_S;
      phase_r <= `PAO_PH1;
      amp_r   <= '0;
    end else begin
      ph_r    <= ph_nxt;
      phase_r <= phase_nxt;
      amp_r   <= amp_nxt;
    end
  end
  assign phase_o     = phase_r;
  assign stage_amp_o = amp_r;

  // ---------------- Alignment delay line ----------------
  // Nine two-bit stage results
  logic [1:0] dly_r   [`PAO_STAGES][ND];   // Per-stage shift taps
  logic [1:0] dly_nxt [`PAO_STAGES][ND];
  pao_raw_t   raw_aligned;                 // Eighteen-bit aligned word
  logic [`PAO_LATENCY-1:0] vpipe_r, vpipe_nxt; // Sample-valid pipeline

  // Shift each stage by its distance
  always_comb begin
    for (int k = 0; k < `PAO_STAGES; k++) begin
      // Two bits per stage, redundancy included
      dly_nxt[k][0] = stage_bits_i[2*`PAO_STAGES+1-2*k -: 2];
      for (int j = 1; j < ND; j++) begin
        dly_nxt[k][j] = dly_r[k][j-1];
      end
    end
  end

  // Gather the aligned word; flash stage taken directly
  always_comb begin
    for (int k = 0; k < `PAO_STAGES; k++) begin
      raw_aligned[`PAO_RAW_BITS-1-2*k -: 2] = dly_r[k][ND-1-k];
    end
    raw_aligned[1:0] = stage_bits_i[1:0];
  end

  // Delay line registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < `PAO_STAGES; k++) begin
        for (int j = 0; j < ND; j++) begin
          dly_r[k][j] <= 2'h0;
        end
      end
    end else begin
      dly_r <= dly_nxt;
    end
  end

  // ---------------- Correction ----------------
  pao_word_t corr_word;   // Corrected two's complement word
  pao_word_t corr_r;      // Correction output register

  pao_corrector u_corr (
    .raw_i  (raw_aligned),
    .word_o (corr_word)
  );

  // ---------------- Output FIFO ----------------
  logic      fifo_in_ready;    // Space available
  pao_word_t fifo_data;        // Head word
  logic      fifo_valid;       // Head present
  logic      corr_valid_r;     // Correction register holds a sample

  // Latency pipeline marks when real samples reach correction
  // Seven-cycle latency tracking
  always_comb begin
    vpipe_nxt = {vpipe_r[`PAO_LATENCY-2:0], 1'b1};
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vpipe_r      <= '0;
      corr_r       <= '0;
      corr_valid_r <= 1'b0;
    end else begin
      vpipe_r      <= vpipe_nxt;
      corr_r       <= corr_word;
      corr_valid_r <= vpipe_r[`PAO_LATENCY-1-`PAO_RETIME-2];
    end
  end

  // ---------------- Latency padding ----------------
  // Plain shift taps between correction and the FIFO. They hold the
  // word and its valid flag side by side so both move in lock step;
  // a word never overtakes its flag, and no tap is ever skipped.
  pao_word_t             pad_r   [`PAO_PAD];  // Word delay taps
  pao_word_t             pad_nxt [`PAO_PAD];  // Next word taps
  logic [`PAO_PAD-1:0]   padv_r;              // Valid delay taps
  logic [`PAO_PAD-1:0]   padv_nxt;            // Next valid taps

  always_comb begin
    // First tap loads from the correction register
    pad_nxt[0]  = corr_r;
    padv_nxt[0] = corr_valid_r;
    // Remaining taps shift one place per clock
    for (int i = 1; i < `PAO_PAD; i++) begin
      pad_nxt[i]  = pad_r[i-1];
      padv_nxt[i] = padv_r[i-1];
    end
  end

  // Padding registers; cleared so no false valid leaves reset
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `PAO_PAD; i++) begin
        pad_r[i] <= '0;
      end
      padv_r <= '0;
    end else begin
      pad_r  <= pad_nxt;
      padv_r <= padv_nxt;
    end
  end

  pao_fifo #(
    .WIDTH (`PAO_OUT_BITS),
    .DEPTH (`PAO_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (sys_clk_i),
    .rst_i       (sys_rst_i),
    .in_data_i   (pad_r[`PAO_PAD-1]),
    .in_valid_i  (padv_r[`PAO_PAD-1]),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (1'b1)
  );

  // ---------------- Retiming and output ----------------
  pao_word_t lat1_r, lat1_nxt;   // First retiming stage
  pao_word_t lat2_r, lat2_nxt;   // Second retiming stage
  logic      v1_r, v1_nxt;
  logic      v2_r, v2_nxt;
  logic [`PAO_OUT_BITS-1:0] oe_r, oe_nxt;  // Bus drive enables
  logic      ovf_r, ovf_nxt;     // Sticky: sample lost at full FIFO

  always_comb begin
    lat1_nxt = fifo_data;
    v1_nxt   = fifo_valid;
    lat2_nxt = output_format_select_i ? lat1_r : flip_msb(lat1_r);
    v2_nxt   = v1_r;
    oe_nxt   = {`PAO_OUT_BITS{~out_enable_n_i}};
    // Cannot occur while drained each cycle; kept for safety
    ovf_nxt  = ovf_r | (padv_r[`PAO_PAD-1] & ~fifo_in_ready);
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lat1_r <= '0;
      lat2_r <= '0;
      v1_r   <= 1'b0;
      v2_r   <= 1'b0;
      oe_r   <= '0;
      ovf_r  <= 1'b0;
    end else begin
      lat1_r <= lat1_nxt;
      lat2_r <= lat2_nxt;
      v1_r   <= v1_nxt;
      v2_r   <= v2_nxt & ~ovf_nxt;
      oe_r   <= oe_nxt;
      ovf_r  <= ovf_nxt;
    end
  end

  assign conversion_result_bus_o    = lat2_r;
  assign conversion_result_bus_oe_o = oe_r;
  assign result_valid_o             = v2_r;
endmodule : pao_top

// file: dv/pao_top_asserts.sv
/* Port-level checker for pao_top, bound into every instance.
   Assumes pao_map.svh is on the include path. */
`timescale 1ns/10ps
`include "pao_map.svh"
module pao_top_chk (
  input wire logic                     sys_clk_i,
  input wire logic                     sys_rst_i,
  input wire logic                     out_enable_n_i,
  input wire logic [`PAO_PHASE_W-1:0]  phase_o,
  input wire logic [`PAO_STAGES:0]     stage_amp_o,
  input wire logic [`PAO_OUT_BITS-1:0] conversion_result_bus_oe_o,
  input wire logic                     result_valid_o
);
  logic [4:0] age_r;   // Cycles since reset, saturating
  logic [4:0] age_nxt; // Next age
  // Count up to the ceiling, then hold
  always_comb begin
    age_nxt = (age_r == 5'h1F) ? age_r : age_r + 5'h1;
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) age_r <= 5'h0;
    else age_r <= age_nxt;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Gap, second phase, gap, first phase
  sequence ph_round_s;
    phase_o == 2'h0 ##1 phase_o == 2'h2 ##1 phase_o == 2'h0 ##1
      phase_o == 2'h1;
  endsequence
  phase_excl_a: assert property (phase_o != 2'h3)
    else $error("both phases high");
  phase_order_a: assert property ($rose(phase_o[0]) |=> ph_round_s)
    else $error("phase order broken");
  phase_gap_a: assert property (phase_o[1] |=> phase_o == 2'h0)
    else $error("no gap after second phase");
  amp_alt_a: assert property (!$past(sys_rst_i) |->
    stage_amp_o[7:0] == ~stage_amp_o[8:1])
    else $error("adjacent stages in same phase");
  oe_follow_a: assert property (!$past(sys_rst_i) |->
    conversion_result_bus_oe_o == {10{!$past(out_enable_n_i)}})
    else $error("drive enable does not follow input");
  valid_hold_a: assert property (result_valid_o |=> result_valid_o)
    else $error("gap in result stream");
  valid_start_a: assert property (age_r >= 5'h18 |-> result_valid_o)
    else $error("results late after reset");
  oe_whole_a: assert property (conversion_result_bus_oe_o == 10'h0 ||
    conversion_result_bus_oe_o == 10'h3FF)
    else $error("partial bus drive");
endmodule : pao_top_chk
bind pao_top pao_top_chk u_pao_top_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .out_enable_n_i(out_enable_n_i), .phase_o(phase_o),
  .stage_amp_o(stage_amp_o), .result_valid_o(result_valid_o),
  .conversion_result_bus_oe_o(conversion_result_bus_oe_o));

// file: dv/pao_capture.sv
/* Capture logic on the far side of the result bus.
   Assumes one clock shared with the converter. */
`timescale 1ns/10ps
module pao_capture (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire pao_pkg::pao_word_t bus_i,
  input  wire pao_pkg::pao_word_t oe_i,
  input  wire logic              valid_i,
  output pao_pkg::pao_word_t     word_o,
  output logic [15:0]            count_o
);
  import pao_pkg::*;
  pao_word_t last_r; // Previous wire level
  pao_word_t pin;    // Wire level; floating bits show the inverse
  assign pin = (bus_i & oe_i) | (~last_r & ~oe_i);
  // Take a word only while the bus is driven and valid
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_r <= '0; word_o <= '0; count_o <= '0;
    end else begin
      last_r <= pin;
      if (valid_i && &oe_i) begin
        word_o <= pin; count_o <= count_o + 16'h1;
      end
    end
  end
endmodule : pao_capture

// file: dv/tb.sv
/* Self-checking bench for pao_top with its capture partner.
   Assumes the design files and pao_pkg are compiled first. */
`timescale 1ns/10ps
module tb;
  import pao_pkg::*;
  logic clk, rst, fmt, oe_n, vld;
  logic [17:0] stage;
  logic [1:0] ph;
  logic [8:0] amp;
  logic [15:0] cnt;
  pao_word_t bus, oe, cap;
  int mismatches, compares, cyc, skip;
  pao_top u_pao_top (.sys_clk_i(clk), .sys_rst_i(rst),
    .stage_bits_i(stage), .output_format_select_i(fmt),
    .out_enable_n_i(oe_n), .phase_o(ph), .stage_amp_o(amp),
    .conversion_result_bus_o(bus), .conversion_result_bus_oe_o(oe),
    .result_valid_o(vld));
  pao_capture u_pao_capture (.clk_i(clk), .rst_i(rst), .bus_i(bus),
    .oe_i(oe), .valid_i(vld), .word_o(cap), .count_o(cnt));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Stage pair j of sample s
  function automatic logic [1:0] pr(input int s, input int j);
    return 2'((s * 5 + j * 3) & 3);
  endfunction : pr
  // Weighted sum of the nine pairs, then format
  function automatic pao_word_t expw(input int s, input logic f);
    logic [10:0] sum = 11'h0;
    for (int j = 0; j < 9; j++) sum += 11'(pr(s, j)) << (8 - j);
    expw = sum[9:0];
    if (f) expw[9] = ~expw[9];
  endfunction : expw
  task automatic check(input string what, input pao_word_t e, g);
    compares++;
    if (e !== g) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check
  // One clock: judge the word due now, then feed the stages
  task automatic step();
    @(negedge clk);
    if (cyc >= 16 && skip == 0) begin
      check("result word", expw(cyc - 16, fmt), bus);
      check("valid", 10'h1, 10'(vld));
    end
    if (skip > 0) skip--;
    for (int j = 0; j < 9; j++) stage[17-2*j -: 2] = pr(cyc - j, j);
    cyc++;
  endtask : step
  task automatic t_stream(input logic f);
    // converter format select takes the level
    fmt = f;
    skip = 4;
    repeat (40) begin
      step();
      if (skip == 0 && cyc >= 18)
        check("captured word", expw(cyc - 18, fmt), cap);
    end
  endtask : t_stream
  task automatic t_oe();
    logic [15:0] n0;
    oe_n = 1'b1;
    step();
    check("bus drive off", 10'h0, oe);
    step();
    n0 = cnt;
    repeat (2) step();
    check("capture held", n0[9:0], cnt[9:0]);
    oe_n = 1'b0;
    step();
    check("bus drive on", 10'h3FF, oe);
  endtask : t_oe
  task automatic stop_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #16000;
    mismatches++;
    stop_test();
  end
  initial begin
    mismatches = 0; compares = 0; cyc = 0; skip = 0;
    rst = 1'b1; fmt = 1'b1; oe_n = 1'b0; stage = '0;
    repeat (5) @(posedge clk);
    check("reset phase", 10'h1, 10'(ph));
    @(negedge clk);
    rst = 1'b0;
    t_stream(1'b1);
    t_stream(1'b0);
    t_oe();
    t_stream(1'b1);
    stop_test();
  end
endmodule : tb
